/* logic/eel_pkg.sv */
// Constants, register map and state encodings for the EEE LPI and wake event block
package eel_pkg;

  localparam int unsigned CLK_MHZ       = 25;
  localparam int unsigned TS_US         = 200;
  localparam int unsigned TQ_US         = 20000;
  localparam int unsigned TR_US         = 200;
  localparam int unsigned TW_US         = 30;
  localparam int unsigned TS_CYC        = TS_US * CLK_MHZ;
  localparam int unsigned TQ_CYC        = TQ_US * CLK_MHZ;
  localparam int unsigned TR_CYC        = TR_US * CLK_MHZ;
  localparam int unsigned TW_CYC        = TW_US * CLK_MHZ;
  localparam int unsigned REC_CYC       = TW_CYC + 16;
  localparam int unsigned EN_UNIT_US    = 1;
  localparam logic [15:0] EN_UNIT_CYC   = 16'(EN_UNIT_US * CLK_MHZ);

  localparam logic [3:0]  A_CTRL        = 4'h0;
  localparam logic [3:0]  A_STATUS      = 4'h1;
  localparam logic [3:0]  A_WAKE_STAT   = 4'h2;
  localparam logic [3:0]  A_WAKE_MASK   = 4'h3;
  localparam logic [3:0]  A_INT_STAT    = 4'h4;
  localparam logic [3:0]  A_INT_MASK    = 4'h5;
  localparam logic [3:0]  A_MAC_LO      = 4'h6;
  localparam logic [3:0]  A_MAC_HI      = 4'h7;
  localparam logic [3:0]  A_EN_TIME     = 4'h8;

  localparam int unsigned CTRL_ADV      = 0;
  localparam int unsigned CTRL_LPI      = 1;
  localparam int unsigned CTRL_PME_SEL  = 2;
  localparam int unsigned WK_ENERGY     = 0;
  localparam int unsigned WK_LINK       = 1;
  localparam int unsigned WK_PKT        = 2;
  localparam int unsigned INT_PME       = 4;

  localparam logic [2:0]  CTRL_RST      = 3'h0;
  localparam logic [2:0]  WMASK_RST     = 3'h0;
  localparam logic [47:0] MAC_RST       = 48'h0;
  localparam logic [7:0]  EN_TIME_RST   = 8'h10;

  localparam logic [3:0]  LPI_TXD       = 4'h1;
  localparam logic [7:0]  SYNC_BYTE     = 8'hff;
  localparam logic [7:0]  SFD_BYTE      = 8'hd5;
  localparam logic [2:0]  SYNC_LEN      = 3'h6;
  localparam logic [4:0]  REP_LEN       = 5'h10;
  localparam logic [31:0] CRC_POLY      = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE   = 32'hdebb20e3;

  typedef enum logic [2:0] {
    PHY_NORM  = 3'b000,
    PHY_SLEEP = 3'b001,
    PHY_QUIET = 3'b010,
    PHY_REFR  = 3'b011,
    PHY_WAKE  = 3'b100
  } eel_phy_e;

  typedef enum logic [1:0] {
    TX_NORM = 2'b00,
    TX_LPI  = 2'b01,
    TX_REC  = 2'b10
  } eel_tx_e;

endpackage

/* logic/eel_top.sv */
// EEE low-power-idle transmit/receive logic, PHY LPI timing and wake event detection
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module eel_top #(
  parameter int unsigned TS_CYC_P  = eel_pkg::TS_CYC,
  parameter int unsigned TQ_CYC_P  = eel_pkg::TQ_CYC,
  parameter int unsigned TR_CYC_P  = eel_pkg::TR_CYC,
  parameter int unsigned TW_CYC_P  = eel_pkg::TW_CYC,
  parameter int unsigned REC_CYC_P = eel_pkg::REC_CYC
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic [5:0]   avs_address_i,
  input  wire logic         avs_read_i,
  input  wire logic         avs_write_i,
  input  wire logic [31:0]  avs_writedata_i,
  input  wire logic [3:0]   avs_byteenable_i,
  output logic [31:0]       avs_readdata_o,
  output logic              avs_waitrequest_o,
  input  wire logic [3:0]   mac_txd_i,
  input  wire logic         mac_txen_i,
  output logic              mac_crs_o,
  output logic [3:0]        mii_txd_o,
  output logic              mii_txen_o,
  output logic              mii_txer_o,
  input  wire logic [3:0]   mii_rxd_i,
  input  wire logic         mii_rxdv_i,
  input  wire logic         mii_rxer_i,
  output logic [3:0]        mac_rxd_o,
  output logic              mac_rxdv_o,
  output logic              mac_rxer_o,
  output logic              partner_idle_flag_o,
  output eel_pkg::eel_phy_e line_sig_o,
  input  eel_pkg::eel_phy_e line_sig_i,
  output logic              rx_power_save_o,
  input  wire logic         an_done_i,
  input  wire logic         partner_eee_adv_i,
  input  wire logic         energy_i,
  input  wire logic         link_up_i,
  output logic              host_irq_out_low_o,
  output logic              power_event_out_o,
  output logic              power_event_out_low_o
);
  import eel_pkg::*;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] mac_byte(input logic [47:0] m, input logic [2:0] k);
    logic [7:0] b;
    b = 8'h00;
    for (int j = 0; j < 6; j++) begin
      if (k == 3'(j)) begin
        b = m[47 - 8*j -: 8];
      end
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [2:0]   ctrl_ff;
  logic [2:0]   wmask_ff;
  logic [2:0]   wstat_ff;
  logic         pme_flag_ff;
  logic         int_mask_ff;
  logic [47:0]  mac_ff;
  logic [7:0]   en_time_ff;
  logic         wait_ff;
  logic [31:0]  rdata_ff;
  logic         acc;
  logic         wr_acc;
  logic         rd_acc;
  logic [3:0]   widx;
  logic [31:0]  bmask;
  logic [31:0]  rd_mux;
  logic         eee_on;
  eel_tx_e      tx_st_ff;
  eel_phy_e     phy_st_ff;
  logic         rx_lpi_ff;
  logic         part_idle_ff;
  logic [2:0]   wk_set;

  assign widx   = avs_address_i[5:2];
  assign acc    = (avs_read_i | avs_write_i) & wait_ff;
  assign wr_acc = acc & avs_write_i;
  assign rd_acc = acc & avs_read_i;
  assign bmask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // Idle high; drops for one cycle per request so each access is taken once
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~acc;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    unique case (widx)
      A_CTRL:      rd_mux = {29'h0, ctrl_ff};
      A_STATUS:    rd_mux = {24'h0, rx_lpi_ff, phy_st_ff, tx_st_ff, part_idle_ff, eee_on};
      A_WAKE_STAT: rd_mux = {29'h0, wstat_ff};
      A_WAKE_MASK: rd_mux = {29'h0, wmask_ff};
      A_INT_STAT:  rd_mux = {27'h0, pme_flag_ff, 4'h0};
      A_INT_MASK:  rd_mux = {27'h0, int_mask_ff, 4'h0};
      A_MAC_LO:    rd_mux = mac_ff[31:0];
      A_MAC_HI:    rd_mux = {16'h0, mac_ff[47:32]};
      A_EN_TIME:   rd_mux = {24'h0, en_time_ff};
      default:     rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 32'h0;
    end else if (rd_acc) begin
      rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_ff     <= CTRL_RST;
      wmask_ff    <= WMASK_RST;
      int_mask_ff <= 1'b0;
      mac_ff      <= MAC_RST;
      en_time_ff  <= EN_TIME_RST;
    end else if (wr_acc) begin
      unique case (widx)
        A_CTRL: begin
          ctrl_ff <= (ctrl_ff & ~bmask[2:0]) | (avs_writedata_i[2:0] & bmask[2:0]);
        end
        A_WAKE_MASK: begin
          wmask_ff <= (wmask_ff & ~bmask[2:0]) | (avs_writedata_i[2:0] & bmask[2:0]);
        end
        A_INT_MASK: begin
          if (avs_byteenable_i[0]) begin
            int_mask_ff <= avs_writedata_i[INT_PME];
          end
        end
        A_MAC_LO: begin
          mac_ff[31:0] <= (mac_ff[31:0] & ~bmask) | (avs_writedata_i & bmask);
        end
        A_MAC_HI: begin
          mac_ff[47:32] <= (mac_ff[47:32] & ~bmask[15:0])
                           | (avs_writedata_i[15:0] & bmask[15:0]);
        end
        A_EN_TIME: begin
          if (avs_byteenable_i[0]) begin
            en_time_ff <= avs_writedata_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // EEE resolution and transmit LPI assert
  logic         lpi_req;
  logic         tx_lpi;
  logic [19:0]  rec_cnt_ff;

  assign eee_on  = an_done_i & partner_eee_adv_i & ctrl_ff[CTRL_ADV];
  assign lpi_req = eee_on & ctrl_ff[CTRL_LPI];
  assign tx_lpi  = (tx_st_ff == TX_LPI);

  // Entry waits for the MAC to be between frames so no frame is cut
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_st_ff   <= TX_NORM;
      rec_cnt_ff <= 20'h0;
    end else begin
      unique case (tx_st_ff)
        TX_NORM: begin
          if (lpi_req && !mac_txen_i && !mii_txen_o) begin
            tx_st_ff <= TX_LPI;
          end
        end
        TX_LPI: begin
          if (!lpi_req) begin
            tx_st_ff   <= TX_REC;
            rec_cnt_ff <= 20'(REC_CYC_P - 1);
          end
        end
        TX_REC: begin
          if (rec_cnt_ff == 20'h0) begin
            tx_st_ff <= TX_NORM;
          end else begin
            rec_cnt_ff <= rec_cnt_ff - 20'h1;
          end
        end
        default: tx_st_ff <= TX_NORM;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mii_txd_o  <= 4'h0;
      mii_txen_o <= 1'b0;
      mii_txer_o <= 1'b0;
      mac_crs_o  <= 1'b0;
    end else begin
      mac_crs_o <= (tx_st_ff != TX_NORM) | (lpi_req & !mac_txen_i);
      if (tx_lpi) begin
        mii_txd_o  <= LPI_TXD;
        mii_txen_o <= 1'b0;
        mii_txer_o <= 1'b1;
      end else if (tx_st_ff == TX_REC) begin
        mii_txd_o  <= 4'h0;
        mii_txen_o <= 1'b0;
        mii_txer_o <= 1'b0;
      end else begin
        mii_txd_o  <= mac_txd_i;
        mii_txen_o <= mac_txen_i;
        mii_txer_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PHY transmit sleep / quiet / refresh / wake timing
  logic [19:0]  phy_cnt_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phy_st_ff  <= PHY_NORM;
      phy_cnt_ff <= 20'h0;
    end else begin
      if (phy_cnt_ff != 20'h0) begin
        phy_cnt_ff <= phy_cnt_ff - 20'h1;
      end
      unique case (phy_st_ff)
        PHY_NORM: begin
          if (tx_lpi) begin
            phy_st_ff  <= PHY_SLEEP;
            phy_cnt_ff <= 20'(TS_CYC_P - 1);
          end
        end
        PHY_SLEEP, PHY_QUIET, PHY_REFR: begin
          if (!tx_lpi) begin
            phy_st_ff  <= PHY_WAKE;
            phy_cnt_ff <= 20'(TW_CYC_P - 1);
          end else if (phy_cnt_ff == 20'h0) begin
            if (phy_st_ff == PHY_QUIET) begin
              phy_st_ff  <= PHY_REFR;
              phy_cnt_ff <= 20'(TR_CYC_P - 1);
            end else begin
              phy_st_ff  <= PHY_QUIET;
              phy_cnt_ff <= 20'(TQ_CYC_P - 1);
            end
          end
        end
        PHY_WAKE: begin
          if (phy_cnt_ff == 20'h0) begin
            phy_st_ff <= PHY_NORM;
          end
        end
        default: phy_st_ff <= PHY_NORM;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_sig_o <= PHY_NORM;
    end else begin
      line_sig_o <= phy_st_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PHY receive LPI and MAC-side LPI detect
  logic [3:0]   rx_d;
  logic         rx_dv;
  logic         rx_er;
  logic         rx_is_lpi;

  // Receive LPI is independent of transmit state
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_lpi_ff <= 1'b0;
    end else if (!eee_on || line_sig_i == PHY_WAKE) begin
      rx_lpi_ff <= 1'b0;
    end else if (line_sig_i == PHY_SLEEP) begin
      rx_lpi_ff <= 1'b1;
    end
  end

  assign rx_d      = rx_lpi_ff ? LPI_TXD : mii_rxd_i;
  assign rx_dv     = rx_lpi_ff ? 1'b0 : mii_rxdv_i;
  assign rx_er     = rx_lpi_ff ? 1'b1 : mii_rxer_i;
  assign rx_is_lpi = !rx_dv && rx_er && (rx_d == LPI_TXD);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mac_rxd_o       <= 4'h0;
      mac_rxdv_o      <= 1'b0;
      mac_rxer_o      <= 1'b0;
      part_idle_ff    <= 1'b0;
      rx_power_save_o <= 1'b0;
    end else begin
      rx_power_save_o <= rx_lpi_ff;
      part_idle_ff    <= rx_is_lpi;
      if (rx_is_lpi) begin
        mac_rxd_o  <= 4'h0;
        mac_rxdv_o <= 1'b0;
        mac_rxer_o <= 1'b0;
      end else begin
        mac_rxd_o  <= rx_d;
        mac_rxdv_o <= rx_dv;
        mac_rxer_o <= rx_er;
      end
    end
  end

  assign partner_idle_flag_o = part_idle_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Wake packet scan over received bytes
  logic         hi_nib_ff;
  logic [3:0]   lo_nib_ff;
  logic         in_frm_ff;
  logic [2:0]   da_idx_ff;
  logic         da_own_ff;
  logic         da_bc_ff;
  logic [2:0]   ff_cnt_ff;
  logic [4:0]   rep_ff;
  logic [2:0]   mi_ff;
  logic         found_ff;
  logic [31:0]  crc_ff;
  logic         dv_q_ff;
  logic [7:0]   rx_byte;
  logic         byte_vld;
  logic         frm_end;
  logic [7:0]   m_b;
  logic         pkt_hit;

  assign rx_byte  = {rx_d, lo_nib_ff};
  assign byte_vld = rx_dv && hi_nib_ff;
  assign frm_end  = dv_q_ff && !rx_dv;
  assign m_b      = mac_byte(mac_ff, mi_ff);
  assign pkt_hit  = frm_end && in_frm_ff && found_ff && wmask_ff[WK_PKT]
                    && (da_own_ff || da_bc_ff) && (crc_ff == CRC_RESIDUE);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hi_nib_ff <= 1'b0;
      lo_nib_ff <= 4'h0;
      dv_q_ff   <= 1'b0;
    end else begin
      dv_q_ff   <= rx_dv;
      hi_nib_ff <= rx_dv & ~hi_nib_ff;
      if (rx_dv && !hi_nib_ff) begin
        lo_nib_ff <= rx_d;
      end
    end
  end

  // Scanner is held cleared unless enabled; failed frames leave no trace
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      in_frm_ff <= 1'b0;
      da_idx_ff <= 3'h0;
      da_own_ff <= 1'b1;
      da_bc_ff  <= 1'b1;
      ff_cnt_ff <= 3'h0;
      rep_ff    <= 5'h0;
      mi_ff     <= 3'h0;
      found_ff  <= 1'b0;
      crc_ff    <= 32'hffffffff;
    end else if (!rx_dv || !wmask_ff[WK_PKT]) begin
      in_frm_ff <= 1'b0;
      da_idx_ff <= 3'h0;
      da_own_ff <= 1'b1;
      da_bc_ff  <= 1'b1;
      ff_cnt_ff <= 3'h0;
      rep_ff    <= 5'h0;
      mi_ff     <= 3'h0;
      found_ff  <= 1'b0;
      crc_ff    <= 32'hffffffff;
    end else if (byte_vld && !in_frm_ff) begin
      in_frm_ff <= (rx_byte == SFD_BYTE);
    end else if (byte_vld) begin
      crc_ff <= crc_byte(crc_ff, rx_byte);
      if (da_idx_ff != SYNC_LEN) begin
        da_own_ff <= da_own_ff && (rx_byte == mac_byte(mac_ff, da_idx_ff));
        da_bc_ff  <= da_bc_ff && (rx_byte == SYNC_BYTE);
        da_idx_ff <= da_idx_ff + 3'h1;
      end
      if (!found_ff) begin
        if (ff_cnt_ff == SYNC_LEN && rx_byte == m_b) begin
          if (mi_ff == 3'h5) begin
            mi_ff <= 3'h0;
            rep_ff <= rep_ff + 5'h1;
            found_ff <= (rep_ff == REP_LEN - 5'h1);
          end else begin
            mi_ff <= mi_ff + 3'h1;
          end
        end else if (rx_byte == SYNC_BYTE) begin
          ff_cnt_ff <= (ff_cnt_ff == SYNC_LEN && rep_ff == 5'h0 && mi_ff == 3'h0)
                       ? SYNC_LEN : ((rep_ff != 5'h0 || mi_ff != 3'h0) ? 3'h1
                       : ff_cnt_ff + 3'h1);
          rep_ff <= 5'h0;
          mi_ff  <= 3'h0;
        end else begin
          ff_cnt_ff <= 3'h0;
          rep_ff    <= 5'h0;
          mi_ff     <= 3'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Energy and link-up wake events
  logic [15:0]  en_cnt_ff;
  logic         en_done_ff;
  logic         link_q_ff;
  logic [15:0]  en_lim;

  assign en_lim = 16'(en_time_ff) * EN_UNIT_CYC;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_cnt_ff  <= 16'h0;
      en_done_ff <= 1'b0;
      link_q_ff  <= 1'b0;
    end else begin
      link_q_ff <= link_up_i;
      if (!energy_i) begin
        en_cnt_ff  <= 16'h0;
        en_done_ff <= 1'b0;
      end else begin
        if (en_cnt_ff != 16'hffff) begin
          en_cnt_ff <= en_cnt_ff + 16'h1;
        end
        if (en_cnt_ff > en_lim) begin
          en_done_ff <= 1'b1;
        end
      end
    end
  end

  assign wk_set[WK_ENERGY] = energy_i && !en_done_ff && (en_cnt_ff > en_lim)
                             && wmask_ff[WK_ENERGY];
  assign wk_set[WK_LINK]   = link_up_i && !link_q_ff && wmask_ff[WK_LINK];
  assign wk_set[WK_PKT]    = pkt_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Wake status, power event flag and host notification
  logic         wclr_hit;
  logic         iclr_hit;

  assign wclr_hit = wr_acc && (widx == A_WAKE_STAT) && avs_byteenable_i[0];
  assign iclr_hit = rd_acc && (widx == A_INT_STAT);

  // New events win over a clear in the same cycle
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wstat_ff    <= 3'h0;
      pme_flag_ff <= 1'b0;
    end else begin
      wstat_ff    <= (wstat_ff & ~(wclr_hit ? avs_writedata_i[2:0] : 3'h0))
                     | wk_set;
      pme_flag_ff <= (pme_flag_ff & ~iclr_hit) | (|wk_set);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_irq_out_low_o    <= 1'b1;
      power_event_out_o     <= 1'b0;
      power_event_out_low_o <= 1'b1;
    end else begin
      host_irq_out_low_o    <= !(pme_flag_ff && int_mask_ff && !ctrl_ff[CTRL_PME_SEL]);
      power_event_out_o     <= pme_flag_ff && int_mask_ff && ctrl_ff[CTRL_PME_SEL];
      power_event_out_low_o <= !(pme_flag_ff && int_mask_ff && ctrl_ff[CTRL_PME_SEL]);
    end
  end

  assign avs_waitrequest_o = wait_ff;
  assign avs_readdata_o    = rdata_ff;

endmodule

/* dv/eel_properties.sv */
// Port checker for LPI timing and receive idle relations
`timescale 1ns/1ps
module eel_properties
  import eel_pkg::*;
#(
  parameter int unsigned TS_CYC_P = 20,
  parameter int unsigned TQ_CYC_P = 50
) (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       an_done_i,
  input wire logic       mac_crs_o,
  input wire logic       mii_txen_o,
  input wire logic       mii_txer_o,
  input wire logic [3:0] mac_rxd_o,
  input wire logic       mac_rxdv_o,
  input wire logic       partner_idle_flag_o,
  input wire eel_phy_e   line_sig_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////
  lpi_blocks_mac_a: assert property (mii_txer_o |-> !mii_txen_o && mac_crs_o)
    else $error("LPI code without deferral");
  defer_first_a: assert property ($rose(mac_crs_o) |=> mii_txer_o)
    else $error("deferral without LPI code");
  recovery_hold_a: assert property ($fell(mii_txer_o) |-> mac_crs_o [*8])
    else $error("MAC released too early");
  eee_gate_a: assert property (!an_done_i [*4] |-> !mii_txer_o)
    else $error("LPI without negotiated EEE");
  rx_idle_shown_a: assert property (partner_idle_flag_o |-> !mac_rxdv_o && mac_rxd_o == 4'h0)
    else $error("receive LPI not shown as idle");
  sleep_start_a: assert property ($rose(mii_txer_o) |=> line_sig_o == PHY_SLEEP)
    else $error("no sleep after LPI start");
  sleep_len_a: assert property ($rose(line_sig_o == PHY_SLEEP) |-> ##TS_CYC_P line_sig_o == PHY_QUIET)
    else $error("sleep length wrong");
  // Only the first quiet: a later one may be cut short by wake
  quiet_len_a: assert property ($rose(line_sig_o == PHY_QUIET) && $past(line_sig_o) == PHY_SLEEP
    |-> ##TQ_CYC_P line_sig_o == PHY_REFR) else $error("quiet length wrong");
endmodule
bind eel_top eel_properties #(.TS_CYC_P(TS_CYC_P), .TQ_CYC_P(TQ_CYC_P))
  u_eel_properties (.*);

/* dv/eel_partner.sv */
// Far-side line state model: sleep then quiet on command, wake on release
`timescale 1ns/1ps
module eel_partner
  import eel_pkg::*;
#(
  parameter int unsigned TW_P = 8
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic lpi_cmd_i,
  output logic      adv_o,
  output eel_phy_e  line_sig_o
);
  logic       cmd_ff;
  logic [3:0] cnt_ff;
  assign adv_o = 1'b1;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_ff     <= 1'b0;
      cnt_ff     <= 4'hf;
      line_sig_o <= PHY_NORM;
    end else begin
      cmd_ff <= lpi_cmd_i;
      if (cmd_ff != lpi_cmd_i) cnt_ff <= 4'h0;
      else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
      // No refresh sent: the receiver must hold LPI through long quiet
      if (cmd_ff) line_sig_o <= (cnt_ff < 4'h4) ? PHY_SLEEP : PHY_QUIET;
      else line_sig_o <= (cnt_ff < TW_P) ? PHY_WAKE : PHY_NORM;
    end
  end
endmodule

/* dv/eel_top_bench.sv */
// Bench: LPI entry and exit, receive LPI, wake packets and wake events
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
`define WAITC(c) begin int k; for (k = 0; k < 2000 && (c) !== 1'b1; k++) \
  @(posedge clk_sys_i); if ((c) !== 1'b1) begin err_total++; \
  $display("[ERR] %0t wait timed out", $time); print_verdict(); end end
module eel_top_bench;
  import eel_pkg::*;
  logic        clk_sys_i, sys_rst_i, avs_read_i, avs_write_i, mac_txen_i, mii_rxdv_i;
  logic        mii_rxer_i, an_done_i, partner_eee_adv_i, energy_i, link_up_i, lpi_cmd;
  logic        avs_waitrequest_o, mac_crs_o, mii_txen_o, mii_txer_o, mac_rxdv_o;
  logic        mac_rxer_o, partner_idle_flag_o, rx_power_save_o, host_irq_out_low_o;
  logic        power_event_out_o, power_event_out_low_o;
  logic [3:0]  mac_txd_i, mii_rxd_i, avs_byteenable_i, mii_txd_o, mac_rxd_o;
  logic [5:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [47:0] mac;
  logic [7:0]  pkt[$];
  eel_phy_e    line_sig_o, line_sig_i;
  int          err_total, n_checks;
  eel_top #(.TS_CYC_P(20), .TQ_CYC_P(50), .TR_CYC_P(10), .TW_CYC_P(8), .REC_CYC_P(16))
    u_eel_top (.*);
  eel_partner u_eel_partner (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .lpi_cmd_i(lpi_cmd), .adv_o(partner_eee_adv_i), .line_sig_o(line_sig_i));
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    avs_address_i <= {a, 2'b00};
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 20) begin
      err_total++;
      $display("[ERR] %0t bus timed out", $time);
      print_verdict();
    end
    @(posedge clk_sys_i);
  endtask
  function automatic logic [31:0] crc();
    logic [31:0] r;
    r = 32'hffffffff;
    foreach (pkt[i]) begin
      r = r ^ {24'h0, pkt[i]};
      repeat (8) r = (r >> 1) ^ (r[0] ? CRC_POLY : 32'h0);
    end
    return ~r;
  endfunction
  // Broadcast destination; random source kept below 0xff so the sync run stays six long
  function automatic void mk(input logic bad);
    logic [31:0] f;
    pkt = {};
    repeat (6) pkt.push_back(8'hff);
    repeat (8) pkt.push_back(8'($urandom) & 8'h7f);
    repeat (6) pkt.push_back(SYNC_BYTE);
    repeat (16) for (int i = 5; i >= 0; i--) pkt.push_back(mac[8*i +: 8]);
    f = crc() ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) pkt.push_back(f[8*i +: 8]);
  endfunction
  task automatic send();
    logic [7:0] b[$];
    b = {SFD_BYTE, pkt};
    repeat (7) b.push_front(8'h55);
    foreach (b[i]) for (int h = 0; h < 2; h++) begin
      mii_rxdv_i <= 1'b1;
      mii_rxd_i <= h ? b[i][7:4] : b[i][3:0];
      @(posedge clk_sys_i);
    end
    mii_rxdv_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {sys_rst_i, avs_read_i, avs_write_i, mac_txen_i, mii_rxdv_i, mii_rxer_i} = 6'h20;
    {an_done_i, energy_i, link_up_i, lpi_cmd} = 4'h0;
    {mac_txd_i, mii_rxd_i, avs_address_i, avs_writedata_i} = '0;
    avs_byteenable_i = 4'hf;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'h7afe5cee));
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    // Lane 0 off: the write must leave the reset value in place
    avs_byteenable_i <= 4'he;
    bus(1'b1, A_EN_TIME, $urandom, q);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, A_EN_TIME, 32'h0, q);
    `CHK(q, {24'h0, EN_TIME_RST})
    bus(1'b0, 4'hf, 32'h0, q);
    `CHK(q, 32'h0)
    bus(1'b1, A_CTRL, 32'h3, q);
    repeat (6) @(posedge clk_sys_i);
    `CHK({mac_crs_o, mii_txer_o}, 2'b00)
    an_done_i <= 1'b1;
    `WAITC(mii_txer_o)
    bus(1'b0, A_STATUS, 32'h0, q);
    `CHK(q, {24'h0, 1'b0, PHY_SLEEP, TX_LPI, 2'b01})
    repeat (6) begin
      mac_txen_i <= 1'b1;
      mac_txd_i <= 4'($urandom);
      @(posedge clk_sys_i);
      `CHK(mii_txen_o, 1'b0)
    end
    mac_txen_i <= 1'b0;
    `WAITC(line_sig_o == PHY_REFR)
    bus(1'b1, A_CTRL, 32'h1, q);
    `WAITC(line_sig_o == PHY_WAKE)
    `WAITC(!mac_crs_o)
    `CHK(line_sig_o, PHY_NORM)
    mac_txen_i <= 1'b1;
    mac_txd_i <= 4'($urandom);
    repeat (2) @(posedge clk_sys_i);
    `CHK({mii_txen_o, mii_txd_o}, {1'b1, mac_txd_i})
    mac_txen_i <= 1'b0;
    lpi_cmd <= 1'b1;
    `WAITC(partner_idle_flag_o)
    `CHK({rx_power_save_o, mac_crs_o}, 2'b10)
    lpi_cmd <= 1'b0;
    `WAITC(!partner_idle_flag_o)
    {mii_rxer_i, mii_rxd_i} <= {1'b1, LPI_TXD};
    repeat (2) @(posedge clk_sys_i);
    `CHK({partner_idle_flag_o, mac_rxdv_o, mac_rxer_o, mac_rxd_o}, 7'h40)
    {mii_rxdv_i, mii_rxd_i} <= {1'b1, 4'he};
    repeat (2) @(posedge clk_sys_i);
    `CHK({partner_idle_flag_o, mac_rxdv_o, mac_rxer_o, mac_rxd_o}, 7'h3e)
    {mii_rxdv_i, mii_rxer_i, mii_rxd_i} <= '0;
    mac = 48'({$urandom, $urandom});
    bus(1'b1, A_MAC_LO, mac[31:0], q);
    bus(1'b1, A_MAC_HI, {16'h0, mac[47:32]}, q);
    bus(1'b1, A_INT_MASK, 32'h10, q);
    bus(1'b1, A_CTRL, 32'h5, q);
    for (int t = 0; t < 3; t++) begin
      bus(1'b1, A_WAKE_MASK, (t > 0) ? 32'h7 : 32'h0, q);
      mk(t == 1);
      send();
      bus(1'b0, A_WAKE_STAT, 32'h0, q);
      `CHK(q[2:0], {t == 2, 2'b00})
    end
    `CHK({power_event_out_o, power_event_out_low_o}, 2'b10)
    bus(1'b0, A_INT_STAT, 32'h0, q);
    `CHK(q[INT_PME], 1'b1)
    bus(1'b0, A_INT_STAT, 32'h0, q);
    `CHK(q[INT_PME], 1'b0)
    bus(1'b1, A_WAKE_STAT, 32'h7, q);
    bus(1'b1, A_EN_TIME, 32'h2, q);
    for (int t = 30; t < 80; t += 40) begin
      energy_i <= 1'b1;
      repeat (t) @(posedge clk_sys_i);
      energy_i <= 1'b0;
      bus(1'b0, A_WAKE_STAT, 32'h0, q);
      `CHK(q[WK_ENERGY], t > 50)
    end
    bus(1'b0, A_INT_STAT, 32'h0, q);
    `CHK({q[INT_PME], power_event_out_o}, 2'b10)
    bus(1'b1, A_CTRL, 32'h1, q);
    `CHK({host_irq_out_low_o, power_event_out_o}, 2'b10)
    link_up_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    bus(1'b0, A_WAKE_STAT, 32'h0, q);
    `CHK(q[2:0], 3'h3)
    `CHK({host_irq_out_low_o, power_event_out_low_o}, 2'b01)
    print_verdict();
  end
endmodule
